// ---- common/apss_consts.svh ----
`ifndef APSS_CONSTS_SVH
`define APSS_CONSTS_SVH

// -----------------------------------------------------------------------------
// Address and mask geometry.
// -----------------------------------------------------------------------------
`define APSS_ADDR_W      40
`define APSS_HASH_MSB    39
`define APSS_HASH_LSB    6
`define APSS_LEN_W       8
`define APSS_ID_W        4
`define APSS_SRAM_PORTS  4
`define APSS_EXT_PORTS   2
`define APSS_SEL_RST     2'h0

`endif

// ---- common/apss_pkg.sv ----
package apss_pkg;

  // ---------------------------------------------------------------------------
  // Transfer request carried from the DMA to a memory port.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [39:0] addr;
    logic [7:0]  len;
    logic [3:0]  id;
    logic        write;
    logic        offchip;
  } apss_req_s;

  typedef logic [1:0] apss_sel_t;

  typedef struct packed {
    logic      valid;
    apss_req_s req;
    apss_sel_t sram_sel;
    logic      ext_sel;
  } apss_state_s;

endpackage : apss_pkg

// ---- logic/apss_stripe_select.sv ----
`timescale 1ns/1ns
`include "apss_consts.svh"
module apss_stripe_select #(
  parameter int HAS_SRAM_HI = 1,
  parameter int HAS_EXT_HI  = 1
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  input  wire logic [`APSS_ADDR_W-1:0]               sram_stripe_mask_lo,
  input  wire logic [`APSS_ADDR_W-1:0]               sram_stripe_mask_hi,
  input  wire logic [`APSS_ADDR_W-1:0]               ext_stripe_mask,
  input  wire logic                                  dma_req_valid,
  input  wire apss_pkg::apss_req_s                   dma_req,
  output logic                                       dma_req_ready,
  input  wire logic [`APSS_SRAM_PORTS-1:0]           sram_port_ready,
  output logic [`APSS_SRAM_PORTS-1:0]                sram_port_valid,
  output apss_pkg::apss_req_s                        sram_port_req,
  input  wire logic [`APSS_EXT_PORTS-1:0]            offchip_mem_port_ready,
  output logic [`APSS_EXT_PORTS-1:0]                 offchip_mem_port_valid,
  output apss_pkg::apss_req_s                        offchip_mem_port_req
);

  // ---------------------------------------------------------------------------
  // Reset release.
  // ---------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Address hash.
  // ---------------------------------------------------------------------------
  logic                sel_lo;
  logic                sel_hi;
  logic                sel_ext;
  apss_pkg::apss_sel_t sram_sel;

  always_comb begin
    sel_lo = ^(sram_stripe_mask_lo[`APSS_HASH_MSB:`APSS_HASH_LSB] &
               dma_req.addr[`APSS_HASH_MSB:`APSS_HASH_LSB]);
    sel_hi = (HAS_SRAM_HI != 0) &&
             (^(sram_stripe_mask_hi[`APSS_HASH_MSB:`APSS_HASH_LSB] &
                dma_req.addr[`APSS_HASH_MSB:`APSS_HASH_LSB]));
    sel_ext = (HAS_EXT_HI != 0) &&
              (^(ext_stripe_mask[`APSS_HASH_MSB:`APSS_HASH_LSB] &
                 dma_req.addr[`APSS_HASH_MSB:`APSS_HASH_LSB]));
    sram_sel = {sel_hi, sel_lo};
  end

  // ---------------------------------------------------------------------------
  // Output stage.
  // ---------------------------------------------------------------------------
  apss_pkg::apss_state_s state_reg;
  apss_pkg::apss_state_s state_next;
  logic                  out_ready;

  always_comb begin
    if (state_reg.req.offchip) begin
      out_ready = offchip_mem_port_ready[state_reg.ext_sel];
    end else begin
      out_ready = sram_port_ready[state_reg.sram_sel];
    end
  end

  always_comb begin
    state_next = state_reg;
    if (state_reg.valid && out_ready) begin
      state_next.valid = 1'b0;
    end
    if (!state_next.valid && dma_req_valid && !state_reg.valid) begin
      state_next.valid    = 1'b1;
      state_next.req      = dma_req;
      state_next.sram_sel = sram_sel;
      state_next.ext_sel  = sel_ext;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg          <= '0;
      state_reg.sram_sel <= `APSS_SEL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered port outputs.
  // ---------------------------------------------------------------------------
  logic [`APSS_SRAM_PORTS-1:0] sram_valid_next;
  logic [`APSS_EXT_PORTS-1:0]  ext_valid_next;

  always_comb begin
    sram_valid_next = '0;
    ext_valid_next  = '0;
    if (state_next.valid && !state_next.req.offchip) begin
      sram_valid_next[state_next.sram_sel] = 1'b1;
    end
    if (state_next.valid && state_next.req.offchip) begin
      ext_valid_next[state_next.ext_sel] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sram_port_valid        <= '0;
      offchip_mem_port_valid <= '0;
      sram_port_req          <= '0;
      offchip_mem_port_req   <= '0;
      dma_req_ready          <= 1'b0;
    end else begin
      sram_port_valid        <= sram_valid_next;
      offchip_mem_port_valid <= ext_valid_next;
      sram_port_req          <= state_next.req;
      offchip_mem_port_req   <= state_next.req;
      dma_req_ready          <= !state_next.valid;
    end
  end

endmodule : apss_stripe_select

// ---- verification/apss_stripe_sva.sv ----
`timescale 1ns/1ns
module apss_stripe_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [39:0] sram_stripe_mask_lo,
  input wire logic [39:0] sram_stripe_mask_hi,
  input wire logic [39:0] ext_stripe_mask,
  input wire logic dma_req_valid,
  input wire apss_pkg::apss_req_s dma_req,
  input wire logic dma_req_ready,
  input wire logic [3:0] sram_port_valid,
  input wire logic [3:0] sram_port_ready,
  input wire apss_pkg::apss_req_s sram_port_req,
  input wire logic [1:0] offchip_mem_port_valid,
  input wire logic [1:0] offchip_mem_port_ready
);
  logic so, eo, ex, ac;
  logic [1:0] ix;
  logic [5:0] v;
  assign so = dma_req_valid & dma_req_ready & !dma_req.offchip;
  assign eo = dma_req_valid & dma_req_ready & dma_req.offchip;
  assign ix = {^(sram_stripe_mask_hi[39:6] & dma_req.addr[39:6]), ^(sram_stripe_mask_lo[39:6] & dma_req.addr[39:6])};
  assign ex = ^(ext_stripe_mask[39:6] & dma_req.addr[39:6]);
  assign v = {offchip_mem_port_valid, sram_port_valid};
  assign ac = |(v & {offchip_mem_port_ready, sram_port_ready});
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sram_route_a: assert property (so |=> v == 6'h1 << $past(ix)) else $error("sram route");
  ext_route_a: assert property (eo |=> v == 6'h10 << $past(ex)) else $error("ext route");
  req_copy_a: assert property (so |=> sram_port_req == $past(dma_req)) else $error("req copy");
  wait_hold_a: assert property (|v & !ac |=> $stable(v)) else $error("hold");
  port_release_a: assert property (ac |=> v == 6'h0 && dma_req_ready) else $error("release");
  busy_refuse_a: assert property (|v |-> !dma_req_ready) else $error("busy");
  one_port_a: assert property ($onehot0(v)) else $error("one port");
  lo_zero_a: assert property (sram_stripe_mask_lo[39:6] == 34'h0 |-> !v[1] && !v[3]) else $error("lo zero");
  both_zero_a: assert property ((sram_stripe_mask_lo[39:6] | sram_stripe_mask_hi[39:6]) == 34'h0 |-> !v[1] && !v[3] && !v[2]) else $error("both zero");
  cover property (so);
  cover property (eo);
  cover property (|v & !ac);
endmodule : apss_stripe_sva
bind apss_stripe_select apss_stripe_sva chk_u (.*);

// ---- verification/apss_port_model.sv ----
`timescale 1ns/1ns
module apss_port_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [5:0] port_valid,
  output logic [5:0] port_ready
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) port_ready <= 6'h0;
    else port_ready <= port_valid & ~port_ready & {6{~stall}};
  end
endmodule : apss_port_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; $display("Error %s %0h %0h", n, e, s); end end
module testbench;
  typedef struct packed {
    logic [39:0] lo;
    logic [39:0] hi;
    logic [39:0] ext;
    logic [39:0] addr;
    logic [5:0]  exp;
  } apss_row_s;
  logic core_clk, rst_n, stall, dma_req_valid, dma_req_ready;
  logic [39:0] mlo, mhi, mext;
  logic [5:0] vld, rdy;
  apss_pkg::apss_req_s dma_req, sram_req, ext_req;
  int failures, n_compared, cyc;
  apss_row_s rows [8];
  apss_stripe_select dut_u (.core_clk(core_clk), .rst_n(rst_n), .sram_stripe_mask_lo(mlo), .sram_stripe_mask_hi(mhi),
    .ext_stripe_mask(mext), .dma_req_valid(dma_req_valid), .dma_req(dma_req), .dma_req_ready(dma_req_ready),
    .sram_port_ready(rdy[3:0]), .sram_port_valid(vld[3:0]), .sram_port_req(sram_req),
    .offchip_mem_port_ready(rdy[5:4]), .offchip_mem_port_valid(vld[5:4]), .offchip_mem_port_req(ext_req));
  apss_port_model mem_u (.core_clk(core_clk), .rst_n(rst_n), .stall(stall), .port_valid(vld), .port_ready(rdy));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic xfer(input apss_row_s r);
    while (dma_req_ready !== 1'b1) @(negedge core_clk);
    mlo = r.lo;
    mhi = r.hi;
    mext = r.ext;
    dma_req = {r.addr, 8'h0F, 4'h3, 1'b1, |r.exp[5:4]};
    dma_req_valid = 1'b1;
    @(negedge core_clk);
    dma_req_valid = 1'b0;
    `CHK("port", r.exp, vld)
    `CHK("req", dma_req, dma_req.offchip ? ext_req : sram_req)
    while (vld !== 6'h0) @(negedge core_clk);
  endtask : xfer
  initial begin
    rst_n = 1'b0;
    stall = 1'b0;
    dma_req_valid = 1'b0;
    dma_req = '0;
    {mlo, mhi, mext} = '0;
    rows = '{'{40'h40, 40'h80, 40'h0, 40'h3F, 6'h01}, '{40'h40, 40'h80, 40'h0, 40'h40, 6'h02},
      '{40'h40, 40'h80, 40'h0, 40'h80, 6'h04}, '{40'h40, 40'h80, 40'h0, 40'hFF, 6'h08},
      '{40'h40, 40'h0, 40'h0, 40'hFFFFFFFFFF, 6'h02}, '{40'h0, 40'h0, 40'h0, 40'hFFFFFFFFFF, 6'h01},
      '{40'h0, 40'h0, 40'h40, 40'h40, 6'h20}, '{40'h0, 40'h0, 40'h40, 40'h80, 6'h10}};
    repeat (20) @(negedge core_clk);
    `CHK("reset", 7'h0, {dma_req_ready, vld})
    rst_n = 1'b1;
    foreach (rows[i]) xfer(rows[i]);
    stall = 1'b1;
    dma_req_valid = 1'b1;
    @(negedge core_clk);
    dma_req_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("stall", 7'h10, {dma_req_ready, vld})
    stall = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("freed", 7'h40, {dma_req_ready, vld})
    close_out();
  end
endmodule : testbench
